// *** aalu_defines.vh ***
/*
  Constants for the accumulator add/AND execution datapath: opcode fields,
  opcode patterns, flag positions and reset values.
  Assumes inclusion by bare name from the datapath files.
*/
`ifndef AALU_DEFINES_VH
`define AALU_DEFINES_VH

// Opcode word and field layout
`define AALU_OPW        14
`define AALU_LIT_MSB    7
`define AALU_ADDR_MSB   6
`define AALU_DEST_BIT   7
`define AALU_TOP6_MSB   13
`define AALU_TOP6_LSB   8
`define AALU_TOP5_MSB   13
`define AALU_TOP5_LSB   9
`define AALU_DATA_W     8

// Opcode patterns
`define AALU_OP_ADDLIT  5'h1f
`define AALU_OP_ANDLIT  6'h39
`define AALU_OP_ADDFILE 6'h07
`define AALU_OP_ANDFILE 6'h05

// Status flag positions within the three-bit flag bus
`define AALU_FLAG_C     0
`define AALU_FLAG_DIGIT 1
`define AALU_FLAG_Z     2

// Reset values
`define AALU_ACC_RST    8'h00
`define AALU_FLAGS_RST  3'h0
`define AALU_ADDR_RST   7'h00
`define AALU_DATA_RST   8'h00
`define AALU_PULSE_RST  1'h0

// Byte value that sets the zero flag
`define AALU_BYTE_ZERO  8'h00

`endif

// *** aalu_adder.v ***
/*
  Eight-bit adder with carry out and digit (nibble) carry, plus zero detect.
  Assumes purely combinational use by the datapath top.
*/
`timescale 1ns/1ps

module aalu_adder (
  input  wire [7:0] opA,
  input  wire [7:0] opB,
  output wire [7:0] sum,
  output wire       carryOut,
  output wire       digitCarry,
  output wire       zero
);

  wire [4:0] lowSum;
  wire [8:0] fullSum;

  // Low nibble carry gives the digit carry, full sum gives the carry
  assign lowSum     = {1'h0, opA[3:0]} + {1'h0, opB[3:0]};
  assign fullSum    = {1'h0, opA} + {1'h0, opB};
  assign sum        = fullSum[7:0];
  assign carryOut   = fullSum[8];
  assign digitCarry = lowSum[4];
  assign zero       = (fullSum[7:0] == 8'h00);

endmodule

// *** aalu_datapath.v ***
/*
  Execution datapath for four accumulator instructions: add and AND of a
  literal into the accumulator, and add and AND of the accumulator with a file
  register, result routed by the destination bit.
  An operation executes on the rising edge of sys_clk at which instrEn is
  high; its results show right after that edge.
  The literal add ignores opcode bit 8; the other three match six top bits.
  Add operations update carry, digit carry and zero; AND operations update
  only zero and keep both carries.
  Destination bit clear writes the accumulator; set writes the file register
  and leaves the accumulator alone.
  The accumulator, the flags and the write data hold until the next executed
  operation; the write strobe and the side-effect flags pulse for one cycle.
  Unrecognised opcodes, and cycles with instrEn low, change nothing but fileAddr, which follows opcode[6:0] every cycle.
  Assumes opcode and operands are stable while instrEn is high, that instrEn is
  the one-cycle instruction-cycle enable from the core's divider, and that the
  core samples port registers from the pins before presenting fileRdData.
  Assumes the core reads the file register at opcode[6:0] in the execute cycle
  and writes fileWrData at fileAddr when fileWrEn pulses.
  Assumes the core clears the timer prescaler when prescalerClear pulses.
*/
`timescale 1ns/1ps
`include "aalu_defines.vh"

// Functional notes
// - Opcode 11 111x adds the literal to the accumulator; updates carry, digit carry, zero.
// - Opcode 11 1001 ANDs the literal with the accumulator; updates only Z.
// - Opcode 00 0111 adds accumulator and addressed file register; updates carry, digit carry, zero.
// - Opcode 00 0101 ANDs accumulator with addressed file register; updates only Z.
// - File operations with destination bit clear write the accumulator only.
// - File operations with destination bit set write the file register only.
// - Port registers are operated on using pin levels, not output latches.
// - Writing the timer count register clears its prescaler when assigned.
module aalu_datapath (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        instrEn,
  input  wire [13:0] opcode,
  input  wire [7:0]  fileRdData,
  input  wire        fileIsPort,
  input  wire        fileIsTimer,
  input  wire        prescalerOnTimer,
  output reg  [7:0]  acc,
  output reg  [2:0]  statusFlags,
  output reg  [6:0]  fileAddr,
  output reg  [7:0]  fileWrData,
  output reg         fileWrEn,
  output reg         prescalerClear,
  output reg         opRecognised,
  output reg         portOperandFromPins
);

  wire [5:0] top6;
  wire [4:0] top5;
  wire [7:0] literal;
  wire       destFile;
  wire       isAddLit;
  wire       isAndLit;
  wire       isAddFile;
  wire       isAndFile;
  wire       isFileOp;
  wire [7:0] addOpB;
  wire [7:0] addSum;
  wire       addC;
  wire       addDigit;
  wire       addZ;
  // AND path and execute qualifiers
  wire [7:0] andOpB;
  wire [7:0] andRes;
  wire       resZero;
  wire       isKnownOp;
  wire       execOp;

  reg  [7:0] result;
  reg        updArith;
  reg        updZero;
  reg        next_toFile;
  // Next values, settled before the executing edge
  reg  [7:0] next_acc;
  reg  [2:0] next_statusFlags;
  reg  [7:0] next_fileWrData;
  reg        next_fileWrEn;
  reg        next_prescalerClear;
  reg        next_opRecognised;
  reg        next_portOperandFromPins;

  // Field extraction
  assign top6     = opcode[`AALU_TOP6_MSB:`AALU_TOP6_LSB];
  assign top5     = opcode[`AALU_TOP5_MSB:`AALU_TOP5_LSB];
  assign literal  = opcode[`AALU_LIT_MSB:0];
  assign destFile = opcode[`AALU_DEST_BIT];

  // Opcode decode
  assign isAddLit  = (top5 == `AALU_OP_ADDLIT);
  assign isAndLit  = (top6 == `AALU_OP_ANDLIT);
  assign isAddFile = (top6 == `AALU_OP_ADDFILE);
  assign isAndFile = (top6 == `AALU_OP_ANDFILE);
  assign isFileOp  = isAddFile | isAndFile;

  // Only the four decoded operations execute; anything else is refused
  assign isKnownOp = isAddLit | isAndLit | isFileOp;
  assign execOp    = instrEn & isKnownOp;

  // Second operands: the file value (pin levels for ports) or the literal
  assign addOpB = isAddFile ? fileRdData : literal;
  assign andOpB = isAndFile ? fileRdData : literal;

  aalu_adder uAdder (
    .opA        (acc),
    .opB        (addOpB),
    .sum        (addSum),
    .carryOut   (addC),
    .digitCarry (addDigit),
    .zero       (addZ)
  );

  // Bitwise AND, one cell per accumulator bit
  genvar gi;
  generate
    for (gi = 0; gi < `AALU_DATA_W; gi = gi + 1) begin : gAndBit
      assign andRes[gi] = acc[gi] & andOpB[gi];
    end
  endgenerate

  // Zero detect on the selected result, used by the AND operations
  assign resZero = (result == `AALU_BYTE_ZERO);

  // Result select and which flags change
  always @* begin
    result      = `AALU_DATA_RST;
    updArith    = 1'h0;
    updZero     = 1'h0;
    next_toFile = 1'h0;
    if (isAddLit) begin
      result   = addSum;
      updArith = 1'h1;
    end else if (isAndLit) begin
      result  = andRes;
      updZero = 1'h1;
    end else if (isAddFile) begin
      result      = addSum;
      updArith    = 1'h1;
      next_toFile = destFile;
    end else if (isAndFile) begin
      result      = andRes;
      updZero     = 1'h1;
      next_toFile = destFile;
    end
  end

  // File address follows the opcode so the core can present read data
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fileAddr <= `AALU_ADDR_RST;
    end else begin
      fileAddr <= opcode[`AALU_ADDR_MSB:0];
    end
  end

  // Next accumulator, flags, write port and pulses for the executing word
  always @* begin
    next_acc                 = acc;
    next_statusFlags         = statusFlags;
    next_fileWrData          = fileWrData;
    next_fileWrEn            = `AALU_PULSE_RST;
    next_prescalerClear      = `AALU_PULSE_RST;
    next_opRecognised        = `AALU_PULSE_RST;
    next_portOperandFromPins = `AALU_PULSE_RST;
    if (execOp) begin
      next_opRecognised        = 1'h1;
      next_portOperandFromPins = isFileOp & fileIsPort;
      if (next_toFile) begin
        next_fileWrData     = result;
        next_fileWrEn       = 1'h1;
        next_prescalerClear = fileIsTimer & prescalerOnTimer;
      end else begin
        next_acc = result;
      end
      if (updArith) begin
        next_statusFlags[`AALU_FLAG_C]     = addC;
        next_statusFlags[`AALU_FLAG_DIGIT] = addDigit;
        next_statusFlags[`AALU_FLAG_Z]     = addZ;
      end else if (updZero) begin
        next_statusFlags[`AALU_FLAG_Z] = resZero;
      end
    end
  end

  // Accumulator and status flags hold between executed operations
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc         <= `AALU_ACC_RST;
      statusFlags <= `AALU_FLAGS_RST;
    end else begin
      acc         <= next_acc;
      statusFlags <= next_statusFlags;
    end
  end

  // Write-back port: data holds, strobe pulses for one cycle
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fileWrData <= `AALU_DATA_RST;
      fileWrEn   <= `AALU_PULSE_RST;
    end else begin
      fileWrData <= next_fileWrData;
      fileWrEn   <= next_fileWrEn;
    end
  end

  // Side-effect and decode pulses, each one cycle wide
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prescalerClear      <= `AALU_PULSE_RST;
      opRecognised        <= `AALU_PULSE_RST;
      portOperandFromPins <= `AALU_PULSE_RST;
    end else begin
      prescalerClear      <= next_prescalerClear;
      opRecognised        <= next_opRecognised;
      portOperandFromPins <= next_portOperandFromPins;
    end
  end

endmodule

// *** aalu_datapath_props.sv ***
/* Checker for the accumulator add/AND datapath.
   Assumes it is bound to aalu_datapath and sees its ports only. */
`timescale 1ns/1ps
module aalu_datapath_props (
  input wire        sys_clk,
  input wire        resetn,
  input wire        instrEn,
  input wire [13:0] opcode,
  input wire [7:0]  fileRdData,
  input wire        fileIsPort,
  input wire        fileIsTimer,
  input wire        prescalerOnTimer,
  input wire [7:0]  acc,
  input wire [2:0]  statusFlags,
  input wire [6:0]  fileAddr,
  input wire [7:0]  fileWrData,
  input wire        fileWrEn,
  input wire        prescalerClear,
  input wire        opRecognised,
  input wire        portOperandFromPins
);
  // Opcode classes taken on this edge
  wire litAdd = instrEn && opcode[13:9] == 5'h1f;
  wire litAnd = instrEn && opcode[13:8] == 6'h39;
  wire fileOp = instrEn && opcode[13:10] == 4'h1 && opcode[8];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  add_lit_a: assert property (
    litAdd |=> {statusFlags[0], acc} == $past(acc) + $past(opcode[7:0])) else $error("literal add wrong");
  and_lit_a: assert property (
    litAnd |=> acc == ($past(acc) & $past(opcode[7:0])) && statusFlags[2] == (acc == 8'h00)
      && $stable(statusFlags[1:0])) else $error("literal and wrong");
  add_file_a: assert property (
    fileOp && opcode[9] |=> {statusFlags[0], ($past(opcode[7]) ? fileWrData : acc)} == $past(acc) + $past(fileRdData))
    else $error("file add wrong");
  and_file_a: assert property (
    fileOp && !opcode[9] |=> $stable(statusFlags[1:0])
      && ($past(opcode[7]) ? fileWrData : acc) == ($past(acc) & $past(fileRdData))
      && statusFlags[2] == (($past(acc) & $past(fileRdData)) == 8'h00))
    else $error("file and wrong");
  dest_route_a: assert property (
    fileOp |=> fileWrEn == $past(opcode[7]) && fileAddr == $past(opcode[6:0])
      && (!$past(opcode[7]) || $stable(acc))) else $error("destination wrong");
  port_pins_a: assert property (
    fileOp |=> portOperandFromPins == $past(fileIsPort)) else $error("port flag wrong");
  pre_clear_a: assert property (
    fileOp && opcode[7] |=> prescalerClear == ($past(fileIsTimer) && $past(prescalerOnTimer))) else $error("prescaler wrong");
  idle_stable_a: assert property (
    !(litAdd || litAnd || fileOp) |=> !opRecognised && !fileWrEn && $stable(acc)) else $error("idle changed state");
  cover property (litAdd ##1 litAdd);
  cover property (fileOp && opcode[7] && fileIsTimer && prescalerOnTimer);
  cover property (fileOp && fileIsPort);
endmodule
bind aalu_datapath aalu_datapath_props i_props (
  .sys_clk             (sys_clk),
  .resetn              (resetn),
  .instrEn             (instrEn),
  .opcode              (opcode),
  .fileRdData          (fileRdData),
  .fileIsPort          (fileIsPort),
  .fileIsTimer         (fileIsTimer),
  .prescalerOnTimer    (prescalerOnTimer),
  .acc                 (acc),
  .statusFlags         (statusFlags),
  .fileAddr            (fileAddr),
  .fileWrData          (fileWrData),
  .fileWrEn            (fileWrEn),
  .prescalerClear      (prescalerClear),
  .opRecognised        (opRecognised),
  .portOperandFromPins (portOperandFromPins)
);

// *** add_and_literal_file_alu_ops_tb.sv ***
/* Self-checking bench for the accumulator add/AND datapath.
   Assumes the datapath and its checker are compiled first. */
`timescale 1ns/1ps
module add_and_literal_file_alu_ops_tb;
  logic        sys_clk = 0;
  logic        resetn = 0;
  logic        instrEn = 0;
  logic [13:0] opcode = 0;
  logic [7:0]  fileRdData = 0;
  logic        fileIsPort = 0;
  logic        fileIsTimer = 0;
  logic        prescalerOnTimer = 0;
  wire  [7:0]  acc;
  wire  [2:0]  statusFlags;
  wire  [6:0]  fileAddr;
  wire  [7:0]  fileWrData;
  wire         fileWrEn, prescalerClear, opRecognised, portOperandFromPins;
  wire  [23:0] outWord;
  int          errorCnt = 0;
  int          compares = 0;
  int          cycles = 0;
  aalu_datapath i_dut (
    .sys_clk             (sys_clk),
    .resetn              (resetn),
    .instrEn             (instrEn),
    .opcode              (opcode),
    .fileRdData          (fileRdData),
    .fileIsPort          (fileIsPort),
    .fileIsTimer         (fileIsTimer),
    .prescalerOnTimer    (prescalerOnTimer),
    .acc                 (acc),
    .statusFlags         (statusFlags),
    .fileAddr            (fileAddr),
    .fileWrData          (fileWrData),
    .fileWrEn            (fileWrEn),
    .prescalerClear      (prescalerClear),
    .opRecognised        (opRecognised),
    .portOperandFromPins (portOperandFromPins)
  );
  // Pulses, flags, accumulator and write data in one word
  assign outWord = {opRecognised, fileWrEn, prescalerClear, portOperandFromPins, 1'h0, statusFlags, acc, fileWrData};
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  task chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Executes one word and judges pulses, flags, acc and write data
  task step(input logic [13:0] op, input logic [7:0] rd, input logic [2:0] c, input logic [23:0] e);
    opcode = op;
    fileRdData = rd;
    {fileIsPort, fileIsTimer, prescalerOnTimer} = c;
    instrEn = 1;
    @(negedge sys_clk);
    chk(outWord, e, "outputs");
  endtask
  task testLiteral;
    step(14'h3e10, 0, 0, 24'h801000);
    step(14'h3e15, 0, 0, 24'h802500);
    step(14'h3fdb, 0, 0, 24'h870000);
    step(14'h3eb0, 0, 0, 24'h80b000);
    step(14'h3ef3, 0, 0, 24'h81a300);
    step(14'h395f, 0, 0, 24'h810300);
    step(14'h3900, 0, 0, 24'h850000);
    $display("Literal test done");
  endtask
  task testFile;
    step(14'h3e17, 0, 0, 24'h801700);
    step(14'h0704, 8'hc2, 0, 24'h80d900);
    step(14'h0584, 8'hc2, 0, 24'hc0d9c0);
    chk({17'h0, fileAddr}, 24'h4, "fileAddr");
    step(14'h0784, 8'h27, 0, 24'hc7d900);
    step(14'h0504, 8'h26, 0, 24'h870000);
    $display("File test done");
  endtask
  task testSide;
    step(14'h0704, 8'h55, 3'h4, 24'h905500);
    step(14'h0781, 8'h01, 3'h3, 24'he05556);
    step(14'h0701, 8'h01, 3'h3, 24'h805656);
    step(14'h0581, 8'hff, 3'h2, 24'hc05656);
    step(14'h3a00, 0, 0, 24'h005656);
    $display("Side effect test done");
  endtask
  // Refused cycle with instrEn low, then a reset in mid-run
  task testIdle;
    step(14'h3e01, 8'h00, 3'h0, 24'h805756);
    instrEn = 0;
    opcode = 14'h3eff;
    @(negedge sys_clk);
    chk(outWord, 24'h005756, "idle");
    resetn = 0;
    @(negedge sys_clk);
    chk(outWord, 24'h000000, "reset");
    chk({17'h0, fileAddr}, 24'h000000, "resetAddr");
    resetn = 1;
    step(14'h3e15, 8'h00, 3'h0, 24'h801500);
    $display("Idle and reset test done");
  endtask
  task finishTest;
    $display("Checks %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 200) begin
      errorCnt++;
      finishTest;
    end
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    resetn = 1;
    testLiteral;
    testFile;
    testSide;
    testIdle;
    finishTest;
  end
endmodule
